// *** logic/two_finger_gesture_engine.sv ***
// two finger tap, scroll and zoom recogniser
`timescale 1ns/1ps
`default_nettype none
`include "tfg_consts.svh"

module two_finger_gesture_engine #(
	parameter int MS_CYCLES = (`TFG_MS_NS + `TFG_CLK_NS - 1) / `TFG_CLK_NS
) (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    cycleStrobe,
	input  wire logic [`TFG_CNT_W-1:0]   touchCount,
	input  wire tfg_pkg::coord_t         touch0X,
	input  wire tfg_pkg::coord_t         touch0Y,
	input  wire tfg_pkg::coord_t         touch1X,
	input  wire tfg_pkg::coord_t         touch1Y,
	input  wire logic                    enTwoFingerTap,
	input  wire logic                    enScroll,
	input  wire logic                    enZoom,
	input  wire tfg_pkg::coord_t         tapDistance,
	input  wire logic [`TFG_TAPT_W-1:0]  tapTime,
	input  wire tfg_pkg::coord_t         scrollInitDist,
	input  wire logic [`TFG_ANGLE_W-1:0] scrollAngle,
	input  wire tfg_pkg::coord_t         zoomInitDist,
	input  wire tfg_pkg::coord_t         zoomConsecDist,
	output logic                         twoFingerTap,
	output logic                         scrollFlag,
	output logic                         zoomFlag,
	output tfg_pkg::rel_t                relX,
	output tfg_pkg::rel_t                relY,
	output logic                         resultStrobe
);

	tfg_pkg::engine_s q, d;
	logic [1:0]       tapOk;
	logic             newPair, cnt2, parX, parY, okX, okY, zInOk, zOutOk, judgeStart;
	tfg_pkg::dist_t   dX0, dX1, dY0, dY1, mX, mY, aMX, aMY, sep, chg, vX, vY;
	logic [`TFG_PROD_W-1:0] perpX, limX, perpY, limY;

	// --------------------------------------------------------------
	// per touch tap qualifiers
	// --------------------------------------------------------------
	assign judgeStart = cycleStrobe && newPair;

	for (genvar t = 0; t < 2; t++) begin : g_judge
		touch_tap_judge u_judge (
			.clk         (clk),
			.rst_n       (rst_n),
			.cycleStrobe (cycleStrobe),
			.msTick      (q.msTick),
			.start       (judgeStart),
			.posX        ((t == 0) ? touch0X : touch1X),
			.posY        ((t == 0) ? touch0Y : touch1Y),
			.tapDistance (tapDistance),
			.tapTime     (tapTime),
			.tapOk       (tapOk[t])
		);
	end

	// --------------------------------------------------------------
	// geometry from the reference and previous coordinates
	// --------------------------------------------------------------
	// reference is the arrival point, rebased at each validated event
	always_comb begin
		cnt2    = (touchCount == `TFG_TWO_TOUCHES);
		newPair = cnt2 && (q.prevCnt != `TFG_TWO_TOUCHES);
		dX0 = tfg_pkg::dist_t'(touch0X) - tfg_pkg::dist_t'(q.refX0);
		dX1 = tfg_pkg::dist_t'(touch1X) - tfg_pkg::dist_t'(q.refX1);
		dY0 = tfg_pkg::dist_t'(touch0Y) - tfg_pkg::dist_t'(q.refY0);
		dY1 = tfg_pkg::dist_t'(touch1Y) - tfg_pkg::dist_t'(q.refY1);
		mX  = (dX0 + dX1) >>> 1;
		mY  = (dY0 + dY1) >>> 1;
		aMX = tfg_pkg::absDist(mX);
		aMY = tfg_pkg::absDist(mY);
		parX = (dX0 > 0 && dX1 > 0) || (dX0 < 0 && dX1 < 0);
		parY = (dY0 > 0 && dY1 > 0) || (dY0 < 0 && dY1 < 0);
		// tangent test without a divider: 64*perp <= angle*along
		perpX = `TFG_PROD_W'($unsigned(aMY)) << `TFG_ANGLE_SHIFT;
		limX  = `TFG_PROD_W'(scrollAngle) * `TFG_PROD_W'($unsigned(aMX));
		perpY = `TFG_PROD_W'($unsigned(aMX)) << `TFG_ANGLE_SHIFT;
		limY  = `TFG_PROD_W'(scrollAngle) * `TFG_PROD_W'($unsigned(aMY));
		okX = enScroll && parX && aMX > tfg_pkg::dist_t'(scrollInitDist) && perpX <= limX;
		okY = enScroll && parY && aMY > tfg_pkg::dist_t'(scrollInitDist) && perpY <= limY;
		// separation, direction of travel does not matter
		sep = tfg_pkg::absDist(tfg_pkg::dist_t'(touch0X) - tfg_pkg::dist_t'(touch1X)) +
			tfg_pkg::absDist(tfg_pkg::dist_t'(touch0Y) - tfg_pkg::dist_t'(touch1Y));
		chg    = sep - q.sepRef;
		zInOk  = enZoom && chg > tfg_pkg::dist_t'(zoomInitDist);
		zOutOk = enZoom && -chg > tfg_pkg::dist_t'(zoomInitDist);
		vX = ((tfg_pkg::dist_t'(touch0X) - tfg_pkg::dist_t'(q.prevX0)) +
			(tfg_pkg::dist_t'(touch1X) - tfg_pkg::dist_t'(q.prevX1))) >>> 1;
		vY = ((tfg_pkg::dist_t'(touch0Y) - tfg_pkg::dist_t'(q.prevY0)) +
			(tfg_pkg::dist_t'(touch1Y) - tfg_pkg::dist_t'(q.prevY1))) >>> 1;
	end

	// --------------------------------------------------------------
	// gesture state machine, evaluated once per processing cycle
	// --------------------------------------------------------------
	always_comb begin
		d      = q;
		d.done = cycleStrobe;
		// millisecond tick for the tap time bound
		d.msTick = (q.msCnt == `TFG_MS_CNT_W'(MS_CYCLES - 1));
		d.msCnt  = d.msTick ? '0 : q.msCnt + `TFG_MS_CNT_W'(1);
		if (cycleStrobe) begin
			d.tap     = 1'b0;
			d.scroll  = 1'b0;
			d.zoom    = 1'b0;
			d.relX    = '0;
			d.relY    = '0;
			d.prevCnt = touchCount;
			d.prevX0  = touch0X;
			d.prevY0  = touch0Y;
			d.prevX1  = touch1X;
			d.prevY1  = touch1Y;
			if (!cnt2) begin
				// both released together from a quiet pair
				if (q.st == tfg_pkg::ARMED && touchCount == `TFG_NO_TOUCHES &&
						enTwoFingerTap && tapOk == 2'b11)
					d.tap = 1'b1;
				d.st = tfg_pkg::IDLE;
			end else if (newPair) begin
				d.st = tfg_pkg::ARMED;
			end else if (q.st != tfg_pkg::IDLE) begin
				case (q.st)
					tfg_pkg::ZOOM_IN: begin
						if (enZoom && chg > tfg_pkg::dist_t'(zoomConsecDist)) begin
							d.zoom = 1'b1;
							d.relX = tfg_pkg::rel_t'(chg);
						end else if (zOutOk) begin
							d.st   = tfg_pkg::ZOOM_OUT;
							d.zoom = 1'b1;
							d.relX = tfg_pkg::rel_t'(chg);
						end else if (okX) begin
							d.st = tfg_pkg::SCROLL_X;
						end else if (okY) begin
							d.st = tfg_pkg::SCROLL_Y;
						end else if (!enZoom) begin
							d.st = tfg_pkg::ARMED;
						end
					end
					tfg_pkg::ZOOM_OUT: begin
						if (enZoom && -chg > tfg_pkg::dist_t'(zoomConsecDist)) begin
							d.zoom = 1'b1;
							d.relX = tfg_pkg::rel_t'(chg);
						end else if (zInOk) begin
							d.st   = tfg_pkg::ZOOM_IN;
							d.zoom = 1'b1;
							d.relX = tfg_pkg::rel_t'(chg);
						end else if (okX) begin
							d.st = tfg_pkg::SCROLL_X;
						end else if (okY) begin
							d.st = tfg_pkg::SCROLL_Y;
						end else if (!enZoom) begin
							d.st = tfg_pkg::ARMED;
						end
					end
					default: begin
						// zoom wins over scroll; scroll axis change revalidates
						if (zInOk || zOutOk) begin
							d.st   = zInOk ? tfg_pkg::ZOOM_IN : tfg_pkg::ZOOM_OUT;
							d.zoom = 1'b1;
							d.relX = tfg_pkg::rel_t'(chg);
						end else if (q.st != tfg_pkg::SCROLL_X && okX) begin
							d.st = tfg_pkg::SCROLL_X;
						end else if (q.st != tfg_pkg::SCROLL_Y && okY) begin
							d.st = tfg_pkg::SCROLL_Y;
						end else if (q.st != tfg_pkg::ARMED && !enScroll) begin
							d.st = tfg_pkg::ARMED;
						end
					end
				endcase
				// rebase on every newly validated gesture or zoom event
				if (d.zoom || d.st != q.st) begin
					d.refX0  = touch0X;
					d.refY0  = touch0Y;
					d.refX1  = touch1X;
					d.refY1  = touch1Y;
					d.sepRef = sep;
				end
				// scroll reports signed per cycle travel on its axis only
				if (d.st == tfg_pkg::SCROLL_X) begin
					d.scroll = 1'b1;
					d.relX   = tfg_pkg::rel_t'(vX);
				end else if (d.st == tfg_pkg::SCROLL_Y) begin
					d.scroll = 1'b1;
					d.relY   = tfg_pkg::rel_t'(vY);
				end
			end
			if (newPair) begin
				d.refX0  = touch0X;
				d.refY0  = touch0Y;
				d.refX1  = touch1X;
				d.refY1  = touch1Y;
				d.sepRef = sep;
			end
		end
	end

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign twoFingerTap = q.tap;
	assign scrollFlag   = q.scroll;
	assign zoomFlag     = q.zoom;
	assign relX         = q.relX;
	assign relY         = q.relY;
	assign resultStrobe = q.done;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	AST_TAP_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_n)
		twoFingerTap && cycleStrobe |=> !twoFingerTap)
		else $error("two finger tap held past one processing cycle");
	AST_TAP_ON_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(twoFingerTap) |-> $past(enTwoFingerTap) && $past(touchCount) == 3'h0)
		else $error("two finger tap without a joint release");
	AST_SCROLL_ONE_AXIS: assert property (@(posedge clk) disable iff (!rst_n)
		scrollFlag |-> (relX == 0 || relY == 0) && !zoomFlag)
		else $error("scroll reports on both axes");
	AST_ZOOM_IN_REL_X: assert property (@(posedge clk) disable iff (!rst_n)
		zoomFlag |-> relY == 0 && relX != 0)
		else $error("zoom magnitude not in relative x");
	AST_COUNT_ENDS: assert property (@(posedge clk) disable iff (!rst_n)
		cycleStrobe && touchCount != 3'h2 |=> !scrollFlag && !zoomFlag && q.st == tfg_pkg::IDLE)
		else $error("gesture survives a touch count other than two");
	AST_HOLD_BETWEEN: assert property (@(posedge clk) disable iff (!rst_n)
		!cycleStrobe |=> $stable(relX) && $stable(scrollFlag) && $stable(zoomFlag) && !resultStrobe)
		else $error("results changed outside a processing cycle");
	AST_SCROLL_OFF: assert property (@(posedge clk) disable iff (!rst_n)
		cycleStrobe && !enScroll |=> !scrollFlag)
		else $error("disabled scroll reported");
	AST_ZOOM_OFF: assert property (@(posedge clk) disable iff (!rst_n)
		cycleStrobe && !enZoom |=> !zoomFlag)
		else $error("disabled zoom reported");
	AST_LIFT_BLOCKS: assert property (@(posedge clk) disable iff (!rst_n)
		cycleStrobe && q.st == tfg_pkg::IDLE && !newPair |=> !scrollFlag && !zoomFlag)
		else $error("gesture validated without a new touch");
	AST_FIRST_SCROLL: assert property (@(posedge clk) disable iff (!rst_n)
		cycleStrobe && q.st == tfg_pkg::ARMED && !okX && !okY |=> !scrollFlag)
		else $error("scroll before initial distance");

endmodule : two_finger_gesture_engine

`default_nettype wire

// *** logic/tfg_consts.svh ***
// constants for the two finger gesture engine
`ifndef TFG_CONSTS_SVH
`define TFG_CONSTS_SVH

`define TFG_COORD_W      16
`define TFG_DIST_W       18
`define TFG_CNT_W        3
`define TFG_TWO_TOUCHES  3'h2
`define TFG_NO_TOUCHES   3'h0
`define TFG_ANGLE_W      8
`define TFG_ANGLE_SHIFT  6
`define TFG_PROD_W       26
`define TFG_MS_NS        1000000
`define TFG_CLK_NS       10
`define TFG_MS_CNT_W     17
`define TFG_TAPT_W       16

`endif

// *** logic/tfg_pkg.sv ***
// types shared by the two finger gesture engine files
`default_nettype none
`include "tfg_consts.svh"

package tfg_pkg;

	typedef logic signed [`TFG_DIST_W-1:0]  dist_t;
	typedef logic signed [`TFG_COORD_W-1:0] rel_t;
	typedef logic [`TFG_COORD_W-1:0]        coord_t;

	typedef enum logic [2:0] {IDLE, ARMED, SCROLL_X, SCROLL_Y, ZOOM_IN, ZOOM_OUT} gest_e;

	// per touch tap qualifier state
	typedef struct packed {
		coord_t                 startX;
		coord_t                 startY;
		logic [`TFG_TAPT_W-1:0] elapsed;
		logic                   ok;
	} judge_s;

	// whole engine state
	typedef struct packed {
		gest_e                    st;
		coord_t                   refX0;
		coord_t                   refY0;
		coord_t                   refX1;
		coord_t                   refY1;
		dist_t                    sepRef;
		coord_t                   prevX0;
		coord_t                   prevY0;
		coord_t                   prevX1;
		coord_t                   prevY1;
		logic [`TFG_CNT_W-1:0]    prevCnt;
		logic [`TFG_MS_CNT_W-1:0] msCnt;
		logic                     msTick;
		logic                     tap;
		logic                     scroll;
		logic                     zoom;
		rel_t                     relX;
		rel_t                     relY;
		logic                     done;
	} engine_s;

	// magnitude of a signed distance
	function automatic dist_t absDist(input dist_t v);
		return (v < 0) ? -v : v;
	endfunction : absDist

endpackage : tfg_pkg

`default_nettype wire

// *** logic/touch_tap_judge.sv ***
// tap qualifier for one touch: movement and duration bound
`timescale 1ns/1ps
`default_nettype none
`include "tfg_consts.svh"

module touch_tap_judge (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   cycleStrobe,
	input  wire logic                   msTick,
	input  wire logic                   start,
	input  wire tfg_pkg::coord_t        posX,
	input  wire tfg_pkg::coord_t        posY,
	input  wire tfg_pkg::coord_t        tapDistance,
	input  wire logic [`TFG_TAPT_W-1:0] tapTime,
	output logic                        tapOk
);

	tfg_pkg::judge_s q, d;
	tfg_pkg::dist_t  dX, dY;

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	// distances always from the first coordinate of the touch
	always_comb begin
		d  = q;
		dX = tfg_pkg::dist_t'(posX) - tfg_pkg::dist_t'(q.startX);
		dY = tfg_pkg::dist_t'(posY) - tfg_pkg::dist_t'(q.startY);
		if (start) begin
			d.startX  = posX;
			d.startY  = posY;
			d.elapsed = '0;
			d.ok      = 1'b1;
		end else begin
			if (msTick && q.elapsed != '1)
				d.elapsed = q.elapsed + `TFG_TAPT_W'(1);
			// must release before the tap time is reached
			if (msTick && ({1'b0, q.elapsed} + 17'h1 >= {1'b0, tapTime}))
				d.ok = 1'b0;
			if (cycleStrobe && (tfg_pkg::absDist(dX) > tfg_pkg::dist_t'(tapDistance) ||
					tfg_pkg::absDist(dY) > tfg_pkg::dist_t'(tapDistance)))
				d.ok = 1'b0;
		end
	end

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign tapOk = q.ok;

endmodule : touch_tap_judge

`default_nettype wire

// *** tb/gesture_host.sv ***
// host side model that tallies the gestures it reads
`timescale 1ns/1ps
`default_nettype none

module gesture_host (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic resultStrobe,
	input  wire logic twoFingerTap,
	input  wire logic scrollFlag,
	input  wire logic zoomFlag,
	output logic [7:0] tapSeen,
	output logic [7:0] scrollSeen,
	output logic [7:0] zoomSeen
);
	// reads once per result pulse only, so a held flag is never counted twice
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tapSeen    <= 8'h0;
			scrollSeen <= 8'h0;
			zoomSeen   <= 8'h0;
		end else if (resultStrobe) begin
			tapSeen    <= tapSeen + {7'h0, twoFingerTap};
			scrollSeen <= scrollSeen + {7'h0, scrollFlag};
			zoomSeen   <= zoomSeen + {7'h0, zoomFlag};
		end
	end
endmodule : gesture_host

`default_nettype wire

// *** tb/two_finger_gesture_engine_bench.sv ***
// self-checking bench for the two finger gesture engine
`timescale 1ns/1ps
`default_nettype none
`include "tfg_consts.svh"

module two_finger_gesture_engine_bench;
	localparam int MS_CYCLES = 10; // short millisecond keeps the tap timeout cheap
	localparam int LIMIT     = 6000;
	localparam int NROWS     = 30;

	// one processing cycle: enables, touches, expected flags and relative data
	typedef struct packed {
		logic [2:0]        en;
		logic [2:0]        cnt;
		logic [7:0]        x0;
		logic [7:0]        y0;
		logic [7:0]        x1;
		logic [7:0]        y1;
		logic [2:0]        fl;
		logic signed [7:0] rx;
		logic signed [7:0] ry;
	} row_s;

	localparam row_s ROWS [NROWS] = '{
		'{3'h7, 3'h0, 8'h0, 8'h0, 8'h0, 8'h0, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h2, 8'h64, 8'h64, 8'hc8, 8'h64, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h2, 8'h69, 8'h69, 8'hcd, 8'h5f, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h0, 8'h69, 8'h69, 8'hcd, 8'h5f, 3'h4, 8'h0, 8'h0},
		'{3'h7, 3'h0, 8'h69, 8'h69, 8'hcd, 8'h5f, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h2, 8'h64, 8'h64, 8'hc8, 8'h64, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h2, 8'h6a, 8'h64, 8'hce, 8'h64, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h2, 8'h70, 8'h65, 8'hd4, 8'h65, 3'h2, 8'h6, 8'h0},
		'{3'h7, 3'h2, 8'h6c, 8'h65, 8'hd0, 8'h65, 3'h2, 8'hfc, 8'h0},
		'{3'h7, 3'h2, 8'h6c, 8'h65, 8'hd0, 8'h65, 3'h2, 8'h0, 8'h0},
		'{3'h7, 3'h2, 8'h62, 8'h65, 8'hda, 8'h65, 3'h2, 8'h0, 8'h0},
		'{3'h7, 3'h2, 8'h60, 8'h65, 8'hdc, 8'h65, 3'h1, 8'h18, 8'h0},
		'{3'h7, 3'h2, 8'h5d, 8'h65, 8'hdf, 8'h65, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h2, 8'h5a, 8'h65, 8'he2, 8'h65, 3'h1, 8'hc, 8'h0},
		'{3'h7, 3'h2, 8'h5f, 8'h65, 8'hdd, 8'h65, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h2, 8'h64, 8'h65, 8'hd6, 8'h65, 3'h1, 8'hea, 8'h0},
		'{3'h7, 3'h3, 8'h64, 8'h65, 8'hd6, 8'h65, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h2, 8'h64, 8'h65, 8'hd6, 8'h65, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h1, 8'h64, 8'h65, 8'hd6, 8'h65, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h1, 8'h96, 8'h65, 8'hd6, 8'h65, 3'h0, 8'h0, 8'h0},
		'{3'h3, 3'h2, 8'h64, 8'h64, 8'hc8, 8'h64, 3'h0, 8'h0, 8'h0},
		'{3'h3, 3'h0, 8'h64, 8'h64, 8'hc8, 8'h64, 3'h0, 8'h0, 8'h0},
		'{3'h5, 3'h2, 8'h64, 8'h64, 8'hc8, 8'h64, 3'h0, 8'h0, 8'h0},
		'{3'h5, 3'h2, 8'h70, 8'h64, 8'hd4, 8'h64, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h0, 8'h70, 8'h64, 8'hd4, 8'h64, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h2, 8'h64, 8'h64, 8'hc8, 8'h64, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h2, 8'h70, 8'h6c, 8'hd4, 8'h6c, 3'h0, 8'h0, 8'h0},
		'{3'h7, 3'h2, 8'h70, 8'h82, 8'hd4, 8'h82, 3'h2, 8'h0, 8'h16},
		'{3'h7, 3'h2, 8'h8c, 8'h82, 8'hf0, 8'h82, 3'h2, 8'h1c, 8'h0},
		'{3'h7, 3'h1, 8'h8c, 8'h82, 8'hf0, 8'h82, 3'h0, 8'h0, 8'h0}
	};

	logic                    clk;
	logic                    rst_n;
	logic                    cycleStrobe;
	logic [`TFG_CNT_W-1:0]   touchCount;
	tfg_pkg::coord_t         touch0X;
	tfg_pkg::coord_t         touch0Y;
	tfg_pkg::coord_t         touch1X;
	tfg_pkg::coord_t         touch1Y;
	logic                    enTwoFingerTap;
	logic                    enScroll;
	logic                    enZoom;
	tfg_pkg::coord_t         tapDistance;
	logic [`TFG_TAPT_W-1:0]  tapTime;
	tfg_pkg::coord_t         scrollInitDist;
	logic [`TFG_ANGLE_W-1:0] scrollAngle;
	tfg_pkg::coord_t         zoomInitDist;
	tfg_pkg::coord_t         zoomConsecDist;
	logic                    twoFingerTap;
	logic                    scrollFlag;
	logic                    zoomFlag;
	tfg_pkg::rel_t           relX;
	tfg_pkg::rel_t           relY;
	logic                    resultStrobe;
	logic [7:0]              tapSeen;
	logic [7:0]              scrollSeen;
	logic [7:0]              zoomSeen;
	int                      failCount;
	int                      nChecks;
	int                      cycles;
	int                      expTap;
	int                      expScroll;
	int                      expZoom;

	two_finger_gesture_engine #(.MS_CYCLES(MS_CYCLES)) i_two_finger_gesture_engine (
		.clk(clk), .rst_n(rst_n), .cycleStrobe(cycleStrobe), .touchCount(touchCount),
		.touch0X(touch0X), .touch0Y(touch0Y), .touch1X(touch1X), .touch1Y(touch1Y),
		.enTwoFingerTap(enTwoFingerTap), .enScroll(enScroll), .enZoom(enZoom),
		.tapDistance(tapDistance), .tapTime(tapTime), .scrollInitDist(scrollInitDist),
		.scrollAngle(scrollAngle), .zoomInitDist(zoomInitDist),
		.zoomConsecDist(zoomConsecDist), .twoFingerTap(twoFingerTap),
		.scrollFlag(scrollFlag), .zoomFlag(zoomFlag), .relX(relX), .relY(relY),
		.resultStrobe(resultStrobe)
	);

	gesture_host i_gesture_host (
		.clk(clk), .rst_n(rst_n), .resultStrobe(resultStrobe),
		.twoFingerTap(twoFingerTap), .scrollFlag(scrollFlag), .zoomFlag(zoomFlag),
		.tapSeen(tapSeen), .scrollSeen(scrollSeen), .zoomSeen(zoomSeen)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic finalReport();
		if (failCount == 0 && nChecks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finalReport

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			failCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// all outputs at once; flags ordered tap, scroll, zoom
	task automatic checkOut(input logic [2:0] fl, input tfg_pkg::rel_t rx, ry, input logic rs);
		check("twoFingerTap", twoFingerTap, fl[2]);
		check("scrollFlag", scrollFlag, fl[1]);
		check("zoomFlag", zoomFlag, fl[0]);
		check("relX", relX, rx);
		check("relY", relY, ry);
		check("resultStrobe", resultStrobe, rs);
	endtask : checkOut

	// one processing cycle: inputs set just after an edge, strobe for one clock
	task automatic drive(input row_s r);
		@(posedge clk);
		#1;
		{enTwoFingerTap, enScroll, enZoom} = r.en;
		touchCount = r.cnt;
		touch0X = tfg_pkg::coord_t'(r.x0);
		touch0Y = tfg_pkg::coord_t'(r.y0);
		touch1X = tfg_pkg::coord_t'(r.x1);
		touch1Y = tfg_pkg::coord_t'(r.y1);
		cycleStrobe = 1'b1;
		@(posedge clk);
		#1;
		cycleStrobe = 1'b0;
	endtask : drive

	// free-running clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			failCount++;
			finalReport();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		cycleStrobe = 1'b0;
		touchCount = '0;
		{touch0X, touch0Y, touch1X, touch1Y} = '0;
		{enTwoFingerTap, enScroll, enZoom} = 3'h7;
		tapDistance = 16'h5;
		tapTime = 16'h14;
		scrollInitDist = 16'ha;
		scrollAngle = 8'h20; // half of 64, so a 2:1 slope is the limit
		zoomInitDist = 16'h14;
		zoomConsecDist = 16'ha;
		{failCount, nChecks, cycles, expTap, expScroll, expZoom} = '0;
		repeat (20) @(posedge clk);
		#1;
		checkOut(3'h0, 16'h0, 16'h0, 1'b0);
		rst_n = 1'b1;
		for (int i = 0; i < NROWS; i++) begin
			drive(ROWS[i]);
			checkOut(ROWS[i].fl, tfg_pkg::rel_t'(ROWS[i].rx), tfg_pkg::rel_t'(ROWS[i].ry), 1'b1);
			@(posedge clk);
			#1;
			checkOut(ROWS[i].fl, tfg_pkg::rel_t'(ROWS[i].rx), tfg_pkg::rel_t'(ROWS[i].ry), 1'b0);
			expTap += int'(ROWS[i].fl[2]);
			expScroll += int'(ROWS[i].fl[1]);
			expZoom += int'(ROWS[i].fl[0]);
		end
		check("tapSeen", tapSeen, expTap[7:0]);
		check("scrollSeen", scrollSeen, expScroll[7:0]);
		check("zoomSeen", zoomSeen, expZoom[7:0]);
		// tap held past its time limit must not count
		drive(ROWS[1]);
		repeat (210) @(posedge clk);
		drive(ROWS[4]);
		checkOut(3'h0, 16'h0, 16'h0, 1'b1);
		// reset in mid-scroll clears everything, then a pair re-arms from fresh origins
		drive(ROWS[25]);
		drive(ROWS[27]);
		check("scrollFlag", scrollFlag, 1'b1);
		rst_n = 1'b0;
		#1;
		checkOut(3'h0, 16'h0, 16'h0, 1'b0);
		@(posedge clk);
		#1;
		rst_n = 1'b1;
		drive(ROWS[28]);
		checkOut(3'h0, 16'h0, 16'h0, 1'b1);
		finalReport();
	end
endmodule : two_finger_gesture_engine_bench

`default_nettype wire
